/* design/cof_objects.sv */
// Communication and programming object bank with TX PDO 8 mapping
//
// Our own choice: the plain strobed port.
`default_nettype none
// How it works
// RULE1 - Mapping record supplies the mapping of transmit PDO eight
// RULE2 - Eight mapping slots at subindices one to eight, each one object
// RULE3 - Each entry is 32 bits, bits 31..16 hold the object index
// RULE4 - Bits 15..8 of an entry hold the object subindex
// RULE5 - Bits 7..0 of an entry hold the object size in bits
// RULE6 - Two read/write programming data slots: firmware area, user area
// RULE7 - One 8-bit control per area, resets to zero, master writable
// RULE8 - One read-only 32-bit status per area, resets to zero
// RULE9 - Entry count of data, control and status reads two, read-only
// RULE10 - After init: selector zero gives pre-operational, bit 3 operational
// RULE11 - Baud code 81h..86h selects 10, 20, 50, 125, 250, 500 kBd
// RULE12 - Code 88h and any unlisted code select 1000 kBd; reset 88h
// RULE13 - Only the first N entries are sent; a count of zero disables
module cof_objects (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [23:0] addr,
  input  wire logic [31:0] wrData,
  input  wire logic        wrEn,
  input  wire logic        rdEn,
  output var  logic [31:0] rdData,
  input  wire logic        txPdoTrigger,
  input  wire logic        nmtReinit,
  output var  logic        nmtOperational,
  output var  logic        nmtPreOperational,
  output var  logic [9:0]  baudKbd,
  output var  logic        progWordValid,
  output var  logic        progWordArea,
  output var  logic [31:0] progWord,
  output var  logic        mapValid,
  output var  logic [2:0]  mapSlot,
  output var  logic [15:0] mapIndex,
  output var  logic [7:0]  mapSub,
  output var  logic [7:0]  mapLen,
  output var  logic        mapDone
);
  // ==========================================================
  // Address decode
  function automatic logic hitObj(logic [23:0] a, logic [15:0] idx);
    hitObj = (a[23:8] == idx);
  endfunction

  function automatic logic hitSub(logic [23:0] a, logic [15:0] idx,
                                  logic [7:0] sub);
    hitSub = (a[23:8] == idx) && (a[7:0] == sub);
  endfunction

  function automatic logic [9:0] baudDecode(logic [7:0] code);
    case (code)
      cof_pkg::BAUD_10:  baudDecode = cof_pkg::KBD_10;
      cof_pkg::BAUD_20:  baudDecode = cof_pkg::KBD_20;
      cof_pkg::BAUD_50:  baudDecode = cof_pkg::KBD_50;
      cof_pkg::BAUD_125: baudDecode = cof_pkg::KBD_125;
      cof_pkg::BAUD_250: baudDecode = cof_pkg::KBD_250;
      cof_pkg::BAUD_500: baudDecode = cof_pkg::KBD_500;
      default:           baudDecode = cof_pkg::KBD_1000;
    endcase
  endfunction

  // ==========================================================
  // Storage
  cof_map_if m ();

  logic [7:0]  mapCount_reg;
  logic [31:0] mapEntry_reg [cof_pkg::SLOTS];
  logic [31:0] progData_reg [cof_pkg::AREAS];
  logic [7:0]  progCtrl_reg [cof_pkg::AREAS];
  logic [31:0] progStat_reg [cof_pkg::AREAS];
  logic [31:0] nmtSel_reg;
  logic [7:0]  baudCode_reg;
  cof_pkg::cof_nmt_t nmtState_reg;
  logic [31:0] rdData_next;

  // ==========================================================
  // Mapping record
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mapCount_reg <= cof_pkg::RST_MAP_CNT;
    end else if (wrEn &&
                 hitSub(addr, cof_pkg::IDX_MAP, cof_pkg::SUB_COUNT)) begin
      mapCount_reg <= wrData[7:0];
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < cof_pkg::SLOTS; gi++) begin : gSlot
      // RULE2 one slot per subindex
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          mapEntry_reg[gi] <= cof_pkg::RST_WORD;
        end else if (wrEn && hitSub(addr, cof_pkg::IDX_MAP,
                                    8'(gi + 1))) begin
          mapEntry_reg[gi] <= wrData;
        end
      end
      assign m.entry[gi] = mapEntry_reg[gi];
    end
  endgenerate

  // RULE1 record drives PDO eight
  assign m.count = mapCount_reg;
  assign m.trigger = txPdoTrigger;

  cof_pdo_walker uWalker (
    .clk   (clk),
    .rst_b (rst_b),
    .m     (m)
  );

  // Walker outputs are already flops
  assign mapValid = m.valid;
  assign mapSlot = m.slot;
  assign mapIndex = m.index;
  assign mapSub = m.sub;
  assign mapLen = m.len;
  assign mapDone = m.done;

  // ==========================================================
  // Programming objects, one set per memory area
  generate
    for (gi = 0; gi < cof_pkg::AREAS; gi++) begin : gArea
      logic dataHit;
      assign dataHit = wrEn &&
                       hitSub(addr, cof_pkg::IDX_PDATA, 8'(gi + 1));

      // RULE6 data slot read/write
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          progData_reg[gi] <= cof_pkg::RST_WORD;
        end else if (dataHit) begin
          progData_reg[gi] <= wrData;
        end
      end

      // RULE7 control resets zero
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          progCtrl_reg[gi] <= cof_pkg::RST_PCTRL;
        end else if (wrEn && hitSub(addr, cof_pkg::IDX_PCTRL,
                                    8'(gi + 1))) begin
          progCtrl_reg[gi] <= wrData[7:0];
        end
      end

      // RULE8 status hardware only
      // Counts words taken while programming is enabled; a zero
      // control clears the count so a new session starts clean.
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          progStat_reg[gi] <= cof_pkg::RST_WORD;
        end else begin
          progStat_reg[gi][31:cof_pkg::STAT_CTRL_LSB] <= progCtrl_reg[gi];
          progStat_reg[gi][23:16] <= 8'h00;
          if (progCtrl_reg[gi] == cof_pkg::RST_PCTRL) begin
            progStat_reg[gi][15:0] <= 16'h0000;
          end else if (dataHit) begin
            progStat_reg[gi][15:0] <= progStat_reg[gi][15:0] +
                                      cof_pkg::ONE16;
          end
        end
      end
    end
  endgenerate

  // Hands each accepted word to the area programmer
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      progWordValid <= 1'b0;
      progWordArea <= 1'b0;
      progWord <= cof_pkg::RST_WORD;
    end else begin
      progWordValid <= 1'b0;
      if (wrEn && hitObj(addr, cof_pkg::IDX_PDATA) &&
          (addr[7:0] == 8'h01 || addr[7:0] == 8'h02) &&
          progCtrl_reg[addr[1]] != cof_pkg::RST_PCTRL) begin
        progWordValid <= 1'b1;
        progWordArea <= addr[1];
        progWord <= wrData;
      end
    end
  end

  // ==========================================================
  // Network start-up
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      nmtSel_reg <= cof_pkg::RST_WORD;
    end else if (wrEn &&
                 hitSub(addr, cof_pkg::IDX_NMT, cof_pkg::SUB_COUNT)) begin
      nmtSel_reg <= wrData;
    end
  end

  // RULE10 choose state after init
  // Only bit 3 is looked at; other selector bits are stored but
  // leave the start-up choice at pre-operational.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      nmtState_reg <= cof_pkg::NMT_INIT;
      nmtOperational <= 1'b0;
      nmtPreOperational <= 1'b0;
    end else begin
      case (nmtState_reg)
        cof_pkg::NMT_INIT: begin
          if (nmtSel_reg[cof_pkg::NMT_OPER_BIT]) begin
            nmtState_reg <= cof_pkg::NMT_OPER;
            nmtOperational <= 1'b1;
            nmtPreOperational <= 1'b0;
          end else begin
            nmtState_reg <= cof_pkg::NMT_PREOP;
            nmtOperational <= 1'b0;
            nmtPreOperational <= 1'b1;
          end
        end
        cof_pkg::NMT_PREOP, cof_pkg::NMT_OPER: begin
          if (nmtReinit) begin
            nmtState_reg <= cof_pkg::NMT_INIT;
            nmtOperational <= 1'b0;
            nmtPreOperational <= 1'b0;
          end
        end
        default: nmtState_reg <= cof_pkg::NMT_INIT;
      endcase
    end
  end

  // ==========================================================
  // Bus baud rate
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      baudCode_reg <= cof_pkg::RST_BAUD;
    end else if (wrEn &&
                 hitSub(addr, cof_pkg::IDX_BAUD, cof_pkg::SUB_COUNT)) begin
      baudCode_reg <= wrData[7:0];
    end
  end

  // RULE11 decode listed codes
  // RULE12 default 1000 kBd
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      baudKbd <= cof_pkg::KBD_1000;
    end else begin
      baudKbd <= baudDecode(baudCode_reg);
    end
  end

  // ==========================================================
  // Read path; unmapped addresses read zero
  always_comb begin
    rdData_next = cof_pkg::RST_WORD;
    case (addr[23:8])
      cof_pkg::IDX_MAP: begin
        if (addr[7:0] == cof_pkg::SUB_COUNT) begin
          rdData_next = {24'h000000, mapCount_reg};
        end else if (addr[7:0] <= 8'(cof_pkg::SLOTS)) begin
          rdData_next = mapEntry_reg[3'(addr[7:0] - 8'h01)];
        end
      end
      // RULE9 area count reads two
      cof_pkg::IDX_PDATA: begin
        if (addr[7:0] == cof_pkg::SUB_COUNT) begin
          rdData_next = {24'h000000, cof_pkg::AREA_COUNT};
        end else if (addr[7:0] == 8'h01 || addr[7:0] == 8'h02) begin
          rdData_next = progData_reg[addr[1]];
        end
      end
      cof_pkg::IDX_PCTRL: begin
        if (addr[7:0] == cof_pkg::SUB_COUNT) begin
          rdData_next = {24'h000000, cof_pkg::AREA_COUNT};
        end else if (addr[7:0] == 8'h01 || addr[7:0] == 8'h02) begin
          rdData_next = {24'h000000, progCtrl_reg[addr[1]]};
        end
      end
      cof_pkg::IDX_PSTAT: begin
        if (addr[7:0] == cof_pkg::SUB_COUNT) begin
          rdData_next = {24'h000000, cof_pkg::AREA_COUNT};
        end else if (addr[7:0] == 8'h01 || addr[7:0] == 8'h02) begin
          rdData_next = progStat_reg[addr[1]];
        end
      end
      cof_pkg::IDX_NMT: begin
        if (addr[7:0] == cof_pkg::SUB_COUNT) begin
          rdData_next = nmtSel_reg;
        end
      end
      cof_pkg::IDX_BAUD: begin
        if (addr[7:0] == cof_pkg::SUB_COUNT) begin
          rdData_next = {24'h000000, baudCode_reg};
        end
      end
      default: rdData_next = cof_pkg::RST_WORD;
    endcase
  end

  // Data stand only in the cycle after the read strobe
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdData <= cof_pkg::RST_WORD;
    end else if (rdEn) begin
      rdData <= rdData_next;
    end else begin
      rdData <= cof_pkg::RST_WORD;
    end
  end

  // ==========================================================
  // Checks
  property p_nmt_start;
    @(posedge clk) disable iff (!rst_b)
      (nmtState_reg == cof_pkg::NMT_INIT)
      |=> (nmtOperational == $past(nmtSel_reg[cof_pkg::NMT_OPER_BIT]))
          && (nmtPreOperational != nmtOperational);
  endproperty
  a_nmt_start: assert property (p_nmt_start) // RULE10
    else $error("start-up state does not follow selector");

  property p_baud125;
    @(posedge clk) disable iff (!rst_b)
      (baudCode_reg == cof_pkg::BAUD_125) |=> (baudKbd == cof_pkg::KBD_125);
  endproperty
  a_baud125: assert property (p_baud125) // RULE11
    else $error("code 84h did not give 125 kBd");

  property p_baud_dflt;
    @(posedge clk) disable iff (!rst_b)
      (baudCode_reg < cof_pkg::BAUD_10 || baudCode_reg > cof_pkg::BAUD_500)
      |=> (baudKbd == cof_pkg::KBD_1000);
  endproperty
  a_baud_dflt: assert property (p_baud_dflt) // RULE12
    else $error("unlisted baud code not 1000 kBd");

  property p_cnt_two;
    @(posedge clk) disable iff (!rst_b)
      (rdEn && hitSub(addr, cof_pkg::IDX_PSTAT, cof_pkg::SUB_COUNT))
      |=> (rdData == 32'h0000_0002);
  endproperty
  a_cnt_two: assert property (p_cnt_two) // RULE9
    else $error("status entry count not two");

  property p_stat_ro;
    @(posedge clk) disable iff (!rst_b)
      (wrEn && hitSub(addr, cof_pkg::IDX_PSTAT, 8'h01) &&
       progCtrl_reg[0] == 8'h00)
      |=> ##1 (progStat_reg[0][15:0] == 16'h0000);
  endproperty
  a_stat_ro: assert property (p_stat_ro) // RULE8
    else $error("status took a bus write");

  property p_ctrl_wr;
    @(posedge clk) disable iff (!rst_b)
      (wrEn && hitSub(addr, cof_pkg::IDX_PCTRL, 8'h02))
      |=> (progCtrl_reg[1] == $past(wrData[7:0]));
  endproperty
  a_ctrl_wr: assert property (p_ctrl_wr) // RULE7
    else $error("control write not stored");

  property p_data_rt;
    @(posedge clk) disable iff (!rst_b)
      (wrEn && hitSub(addr, cof_pkg::IDX_PDATA, 8'h01))
      ##1 (rdEn && hitSub(addr, cof_pkg::IDX_PDATA, 8'h01))
      |=> (rdData == $past(wrData, 2));
  endproperty
  a_data_rt: assert property (p_data_rt) // RULE6
    else $error("data slot did not read back");

  property p_entry_rt;
    @(posedge clk) disable iff (!rst_b)
      (wrEn && hitSub(addr, cof_pkg::IDX_MAP, 8'h08))
      ##1 (rdEn && hitSub(addr, cof_pkg::IDX_MAP, 8'h08))
      |=> (rdData == $past(wrData, 2));
  endproperty
  a_entry_rt: assert property (p_entry_rt) // RULE2
    else $error("mapping slot eight did not read back");

  property p_fields;
    @(posedge clk) disable iff (!rst_b)
      mapValid |-> (mapIndex == mapEntry_reg[mapSlot][31:16]) &&
                   (mapSub == mapEntry_reg[mapSlot][15:8]) &&
                   (mapLen == mapEntry_reg[mapSlot][7:0]);
  endproperty
  a_fields: assert property (p_fields) // RULE3
    else $error("mapped fields differ from entry");

  property p_limit;
    @(posedge clk) disable iff (!rst_b)
      mapValid |-> (9'(mapSlot) < 9'(mapCount_reg));
  endproperty
  a_limit: assert property (p_limit) // RULE13
    else $error("slot beyond entry count emitted");
endmodule
`default_nettype wire

/* include/cof_pkg.sv */
// Constants, types and field decoders of the comm object bank
`default_nettype none
package cof_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 24;
  localparam int SLOTS = 8;
  localparam int AREAS = 2;
  localparam int SLOT_W = 3;
  // Object indices; address is {index, subindex}
  localparam logic [15:0] IDX_MAP = 16'h1A07;
  localparam logic [15:0] IDX_PDATA = 16'h1F50;
  localparam logic [15:0] IDX_PCTRL = 16'h1F51;
  localparam logic [15:0] IDX_PSTAT = 16'h1F57;
  localparam logic [15:0] IDX_NMT = 16'h1F80;
  localparam logic [15:0] IDX_BAUD = 16'h2005;
  localparam logic [7:0] SUB_COUNT = 8'h00;
  localparam logic [7:0] SUB_FIRST = 8'h01;
  localparam logic [7:0] AREA_COUNT = 8'h02;
  // Reset values
  localparam logic [7:0] RST_MAP_CNT = 8'h00;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [7:0] RST_PCTRL = 8'h00;
  localparam logic [7:0] RST_BAUD = 8'h88;
  localparam int NMT_OPER_BIT = 3;
  // Status layout: [31:24] control echo, [15:0] words taken
  localparam int STAT_CTRL_LSB = 24;
  localparam logic [15:0] ONE16 = 16'h0001;
  // Baud codes and rates in kBd
  localparam logic [7:0] BAUD_10 = 8'h81;
  localparam logic [7:0] BAUD_20 = 8'h82;
  localparam logic [7:0] BAUD_50 = 8'h83;
  localparam logic [7:0] BAUD_125 = 8'h84;
  localparam logic [7:0] BAUD_250 = 8'h85;
  localparam logic [7:0] BAUD_500 = 8'h86;
  localparam logic [9:0] KBD_10 = 10'h00A;
  localparam logic [9:0] KBD_20 = 10'h014;
  localparam logic [9:0] KBD_50 = 10'h032;
  localparam logic [9:0] KBD_125 = 10'h07D;
  localparam logic [9:0] KBD_250 = 10'h0FA;
  localparam logic [9:0] KBD_500 = 10'h1F4;
  localparam logic [9:0] KBD_1000 = 10'h3E8;
  typedef enum {NMT_INIT, NMT_PREOP, NMT_OPER} cof_nmt_t;
  typedef enum {MW_IDLE, MW_WALK} cof_walk_t;
  function automatic logic [15:0] map_index(logic [31:0] e);
    map_index = e[31:16];
  endfunction
  function automatic logic [7:0] map_sub(logic [31:0] e);
    map_sub = e[15:8];
  endfunction
  function automatic logic [7:0] map_len(logic [31:0] e);
    map_len = e[7:0];
  endfunction
endpackage
`default_nettype wire

/* include/cof_map_if.sv */
// Carrier between the object bank and the PDO mapping walker
`default_nettype none
interface cof_map_if;
  logic [7:0]  count;
  logic [31:0] entry [cof_pkg::SLOTS];
  logic        trigger;
  logic        busy;
  logic        valid;
  logic        done;
  logic [2:0]  slot;
  logic [15:0] index;
  logic [7:0]  sub;
  logic [7:0]  len;
  modport bank (output count, entry, trigger,
                input busy, valid, done, slot, index, sub, len);
  modport walk (input count, entry, trigger,
                output busy, valid, done, slot, index, sub, len);
endinterface
`default_nettype wire

/* design/cof_pdo_walker.sv */
// Walks the active mapping entries of the eighth transmit PDO
`default_nettype none
module cof_pdo_walker (
  input  wire logic clk,
  input  wire logic rst_b,
  cof_map_if.walk   m
);
  cof_pkg::cof_walk_t st_reg;
  logic [2:0]         cur_reg;
  logic [2:0]         last;
  // Counts above the slot total are clamped to eight
  assign last = (m.count > 8'(cof_pkg::SLOTS)) ? 3'(cof_pkg::SLOTS - 1)
                                              : 3'(m.count - 8'h01);
  assign m.busy = (st_reg == cof_pkg::MW_WALK);

  // RULE13 count bounds walk
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_reg <= cof_pkg::MW_IDLE;
      cur_reg <= '0;
      m.valid <= 1'b0;
      m.done <= 1'b0;
      m.slot <= '0;
      m.index <= '0;
      m.sub <= '0;
      m.len <= '0;
    end else begin
      m.valid <= 1'b0;
      m.done <= 1'b0;
      case (st_reg)
        cof_pkg::MW_IDLE: begin
          if (m.trigger && m.count != cof_pkg::RST_MAP_CNT) begin
            st_reg <= cof_pkg::MW_WALK;
            cur_reg <= '0;
          end
        end
        cof_pkg::MW_WALK: begin
          // RULE3 index field
          m.index <= cof_pkg::map_index(m.entry[cur_reg]);
          // RULE4 subindex field
          m.sub <= cof_pkg::map_sub(m.entry[cur_reg]);
          // RULE5 length field
          m.len <= cof_pkg::map_len(m.entry[cur_reg]);
          m.valid <= 1'b1;
          m.slot <= cur_reg;
          if (cur_reg == last) begin
            m.done <= 1'b1;
            st_reg <= cof_pkg::MW_IDLE;
          end else begin
            cur_reg <= cur_reg + 3'h1;
          end
        end
        default: st_reg <= cof_pkg::MW_IDLE;
      endcase
    end
  end

  property p_zero_off;
    @(posedge clk) disable iff (!rst_b)
      (st_reg == cof_pkg::MW_IDLE && m.trigger && m.count == 8'h00)
      |=> !m.busy ##1 !m.valid;
  endproperty
  a_zero_off: assert property (p_zero_off) // RULE13
    else $error("walk started with zero entry count");

  property p_three;
    @(posedge clk) disable iff (!rst_b)
      (st_reg == cof_pkg::MW_IDLE && m.trigger && m.count == 8'h03)
      |-> ##2 m.valid [*3] ##0 m.done;
  endproperty
  a_three: assert property (p_three) // RULE13
    else $error("three-entry walk did not emit three slots");
endmodule
`default_nettype wire

/* dv/cof_master_model.sv */
// Register-bus master standing in for the fieldbus master
`default_nettype none
module cof_master_model (
  input  wire logic        clk,
  output var  logic [23:0] addr,
  output var  logic [31:0] wrData,
  output var  logic        wrEn,
  output var  logic        rdEn,
  input  wire logic [31:0] rdData
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    addr = 24'h000000;
    wrData = 32'h00000000;
    wrEn = 1'b0;
    rdEn = 1'b0;
  end
  // ==========
  // Bus cycles
  // Idle bus shows the inverse, so a stale value never passes for data
  task automatic wr(input logic [23:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wrEn <= 1'b1;
    @(posedge clk);
    wrEn <= 1'b0;
    addr <= ~a;
    wrData <= ~d;
  endtask
  task automatic rd(input logic [23:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge clk);
    rdEn <= 1'b0;
    addr <= ~a;
    #1;
    d = rdData;
  endtask
  // Write then read with no idle cycle between the two strobes
  task automatic wrRd(input logic [23:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wrEn <= 1'b1;
    @(posedge clk);
    wrEn <= 1'b0;
    rdEn <= 1'b1;
    @(posedge clk);
    rdEn <= 1'b0;
    addr <= ~a;
    wrData <= ~d;
    #1;
    q = rdData;
  endtask
endmodule
`default_nettype wire

/* dv/test_canopen_comm_config_objects.sv */
// Self-checking bench of the comm object bank
`default_nettype none
module test_canopen_comm_config_objects;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rstB = 1'b0;
  logic [23:0] addr;
  logic [31:0] wrData;
  logic        wrEn;
  logic        rdEn;
  logic [31:0] rdData;
  logic        txPdoTrigger = 1'b0;
  logic        nmtReinit = 1'b0;
  logic        nmtOperational;
  logic        nmtPreOperational;
  logic [9:0]  baudKbd;
  logic        progWordValid;
  logic        progWordArea;
  logic [31:0] progWord;
  logic        mapValid;
  logic [2:0]  mapSlot;
  logic [15:0] mapIndex;
  logic [7:0]  mapSub;
  logic [7:0]  mapLen;
  logic        mapDone;
  int          numErrors = 0;
  int          checksDone = 0;
  int          cycles = 0;
  int          pulseCount = 0;
  logic        lastArea;
  logic [31:0] lastWord;
  logic [7:0]  codes [10] = '{8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86,
                              8'h88, 8'h87, 8'h00, 8'hFF};
  logic [9:0]  rates [10] = '{cof_pkg::KBD_10, cof_pkg::KBD_20,
    cof_pkg::KBD_50, cof_pkg::KBD_125, cof_pkg::KBD_250, cof_pkg::KBD_500,
    cof_pkg::KBD_1000, cof_pkg::KBD_1000, cof_pkg::KBD_1000,
    cof_pkg::KBD_1000};

  always #12.5 clk = ~clk;

  cof_master_model master (.clk(clk), .addr(addr), .wrData(wrData),
    .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData));

  cof_objects DUT (.clk(clk), .rst_b(rstB), .addr(addr), .wrData(wrData),
    .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .txPdoTrigger(txPdoTrigger),
    .nmtReinit(nmtReinit), .nmtOperational(nmtOperational),
    .nmtPreOperational(nmtPreOperational), .baudKbd(baudKbd),
    .progWordValid(progWordValid), .progWordArea(progWordArea),
    .progWord(progWord), .mapValid(mapValid), .mapSlot(mapSlot),
    .mapIndex(mapIndex), .mapSub(mapSub), .mapLen(mapLen),
    .mapDone(mapDone));

  // ==========
  // Helpers
  always @(posedge clk) begin
    if (progWordValid === 1'b1) begin
      pulseCount++;
      lastArea = progWordArea;
      lastWord = progWord;
    end
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      numErrors++;
      tallyAndFinish();
    end
  end
  task automatic tallyAndFinish();
    $display("checks %0d mismatches %0d", checksDone, numErrors);
    if (numErrors == 0 && checksDone > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      numErrors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rdChk(input logic [23:0] a, input logic [31:0] exp);
    logic [31:0] d;
    master.rd(a, d);
    chk(d, exp);
  endtask
  // Distinct index, subindex and size per slot
  function automatic logic [31:0] entry(input logic [7:0] i);
    entry = {8'h60, i, i, 8'h08 + i};
  endfunction
  task automatic doReset();
    @(posedge clk);
    rstB <= 1'b0;
    repeat (8) @(posedge clk);
    rstB <= 1'b1;
    @(posedge clk);
    #1;
  endtask

  // ==========
  // Scenarios
  task automatic testReset();
    chk({30'h0, nmtOperational, nmtPreOperational}, 32'h1);
    chk({22'h0, baudKbd}, 32'h3E8);
    rdChk(24'h1A0700, 32'h0);
    for (int i = 1; i <= 8; i++) rdChk({16'h1A07, 8'(i)}, 32'h0);
    rdChk(24'h1F5000, 32'h2);
    rdChk(24'h1F5100, 32'h2);
    rdChk(24'h1F5700, 32'h2);
    rdChk(24'h1F5101, 32'h0);
    rdChk(24'h1F5102, 32'h0);
    rdChk(24'h1F5701, 32'h0);
    rdChk(24'h1F5702, 32'h0);
    rdChk(24'h1F8000, 32'h0);
    rdChk(24'h200500, 32'h88);
    $display("test reset values done");
  endtask
  task automatic walk(input logic [7:0] cnt, input int n);
    int k;
    k = 0;
    master.wr(24'h1A0700, {24'h0, cnt});
    @(posedge clk);
    txPdoTrigger <= 1'b1;
    // Held into the busy cycle: a second trigger must be ignored
    repeat (2) @(posedge clk);
    txPdoTrigger <= 1'b0;
    // First slot stands right after the edge that ends the busy cycle
    for (int c = 0; c < 14; c++) begin
      #1;
      if (mapValid === 1'b1) begin
        chk({29'h0, mapSlot}, k);
        chk({mapIndex, mapSub, mapLen}, entry(8'(k + 1)));
        chk({31'h0, mapDone}, {31'h0, k == n - 1});
        k++;
      end
      @(posedge clk);
    end
    chk(k, n);
  endtask
  task automatic testMapping();
    logic [31:0] got;
    for (int i = 1; i <= 8; i++) master.wr({16'h1A07, 8'(i)}, entry(8'(i)));
    for (int i = 1; i <= 8; i++) begin
      rdChk({16'h1A07, 8'(i)}, entry(8'(i)));
    end
    master.wrRd(24'h1A0708, entry(8'h08), got);
    chk(got, entry(8'h08));
    rdChk(24'h1A0709, 32'h0);
    walk(8'h03, 3);
    walk(8'h00, 0);
    walk(8'h08, 8);
    walk(8'h09, 8);
    $display("test mapping done");
  endtask
  task automatic testReadOnly();
    master.wr(24'h1F5000, 32'hFFFFFFFF);
    master.wr(24'h1F5100, 32'hFFFFFFFF);
    master.wr(24'h1F5700, 32'hFFFFFFFF);
    master.wr(24'h1F5701, 32'hFFFFFFFF);
    master.wr(24'h1F5702, 32'hFFFFFFFF);
    master.wr(24'h123456, 32'hFFFFFFFF);
    rdChk(24'h1F5000, 32'h2);
    rdChk(24'h1F5100, 32'h2);
    rdChk(24'h1F5700, 32'h2);
    rdChk(24'h1F5701, 32'h0);
    rdChk(24'h1F5702, 32'h0);
    rdChk(24'h123456, 32'h0);
    $display("test read-only done");
  endtask
  task automatic testProgram();
    logic [7:0] ctl;
    logic [31:0] dat;
    logic [31:0] got;
    int pre;
    for (int a = 1; a <= 2; a++) begin
      ctl = 8'h10 + 8'(a);
      dat = 32'hC0DE0000 + 32'(a);
      master.wr({16'h1F51, 8'(a)}, {24'h0, ctl});
      rdChk({16'h1F51, 8'(a)}, {24'h0, ctl});
      pre = pulseCount;
      master.wrRd({16'h1F50, 8'(a)}, dat, got);
      chk(got, dat);
      repeat (3) @(posedge clk);
      #1;
      chk(pulseCount, pre + 1);
      chk({31'h0, lastArea}, a - 1);
      chk(lastWord, dat);
      rdChk({16'h1F50, 8'(a)}, dat);
      rdChk({16'h1F57, 8'(a)}, {ctl, 8'h00, 16'h0001});
      master.wr({16'h1F51, 8'(a)}, 32'h0);
      rdChk({16'h1F57, 8'(a)}, 32'h0);
    end
    $display("test programming done");
  endtask
  task automatic testNmt();
    logic [31:0] sel [2] = '{32'h8, 32'h0};
    logic [1:0] st [2] = '{2'b10, 2'b01};
    for (int i = 0; i < 2; i++) begin
      master.wr(24'h1F8000, sel[i]);
      @(posedge clk);
      nmtReinit <= 1'b1;
      @(posedge clk);
      nmtReinit <= 1'b0;
      #1;
      chk({30'h0, nmtOperational, nmtPreOperational}, 32'h0);
      @(posedge clk);
      #1;
      chk({30'h0, nmtOperational, nmtPreOperational}, st[i]);
    end
    $display("test network start-up done");
  endtask
  task automatic testBaud();
    for (int i = 0; i < 10; i++) begin
      master.wr(24'h200500, {24'h0, codes[i]});
      repeat (3) @(posedge clk);
      #1;
      chk({22'h0, baudKbd}, {22'h0, rates[i]});
      rdChk(24'h200500, {24'h0, codes[i]});
    end
    $display("test bit rate done");
  endtask

  initial begin
    doReset();
    testReset();
    testMapping();
    testReadOnly();
    testProgram();
    testNmt();
    testBaud();
    // A second reset must bring every object except the data slots, which testReset does not read, back to its reset value
    doReset();
    testReset();
    tallyAndFinish();
  end
endmodule
`default_nettype wire
